//--- core/fpesc_pkg.sv
// Constants and carrier types for the flash program/erase/suspend sequencer.
// Assumes a 250 MHz system clock; link pins are sampled, not used as clocks.
// Behaviour
// - 4-byte program opcodes carry 32-bit address
// - Address width from config or enter/exit
// - Dedicated 4-byte opcodes always use 4 bytes
// - Command on one line, address clocks per line width
// - Erase leaves target region all ones
// - Erase without write enable silently ignored
// - Chip select off byte boundary aborts command
// - Protected subsector erase refused, bits 1,5
// - Die erase refused if any sector locked
// - Busy: ready bit low, in-progress high
// - Write enable cleared after every erase
// - Erase timeout clears latch, sets error
// - Self-timed erase, per-kind durations
// - Any address in region, rising-edge latched
// - Suspend opcode pauses program or erase
// - Program suspend bit 2, erase bit 6
// - Bit 7 set after suspend latency
// - Short remainder completes instead, clears flag
// - Reset forgets suspend, flags read 80h
// - One nesting level, resume program first
// - Idle and accepting commands while suspended
// - Suspend 75h, resume 7Ah shared
// - Resume with nothing suspended ignored
// - Program to erase-suspended sector fails, bit 4
`default_nettype none
package fpesc_pkg;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_PP = 8'h02;
    localparam logic [7:0] OP_QPP = 8'h32;
    localparam logic [7:0] OP_PP4 = 8'h12;
    localparam logic [7:0] OP_QPP4 = 8'h34;
    localparam logic [7:0] OP_EN4 = 8'hb7;
    localparam logic [7:0] OP_EX4 = 8'he9;
    localparam logic [7:0] OP_SUSP = 8'h75;
    localparam logic [7:0] OP_RESM = 8'h7a;
    localparam logic [7:0] OP_CLRF = 8'h50;
    localparam logic [7:0] FLAG_RESET = 8'h80;
    localparam int FLAG_READY = 7;
    localparam int FLAG_ERSUSP = 6;
    localparam int FLAG_ERERR = 5;
    localparam int FLAG_PGERR = 4;
    localparam int FLAG_PGSUSP = 2;
    localparam int FLAG_PROT = 1;
    localparam int CLK_NS = 4;
    localparam int SUSP_LAT_NS = 40;
    localparam int SUSP_LAT_CYC = (SUSP_LAT_NS + CLK_NS - 1) / CLK_NS;
    localparam int SECTOR_LSB = 16;

    typedef enum logic [1:0] {
        FPESC_K_PROG = 2'b00,
        FPESC_K_SSE = 2'b01,
        FPESC_K_SE = 2'b10,
        FPESC_K_DIE = 2'b11
    } fpesc_kind_t;

    // One array operation that may be running or parked
    typedef struct packed {
        logic active;
        fpesc_kind_t kind;
        logic [31:0] addr;
        logic [31:0] remain;
        logic [31:0] elapsed;
    } fpesc_op_t;

    // Completed frame from the link shifter
    typedef struct packed {
        logic valid;
        logic [7:0] opcode;
        logic [31:0] addr;
        logic [5:0] bytes;
        logic aligned;
    } fpesc_frame_t;
endpackage
`default_nettype wire

//--- core/fpesc_link_rx.sv
// Link receiver: samples chip select, serial clock and data lines.
// Assumes host-driven link clock far slower than clk_sys.
`default_nettype none
module fpesc_link_rx
    import fpesc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic chipSelN,
    input wire logic serialClk,
    input wire logic [3:0] serialDataLines,
    input wire logic [1:0] lineMode,
    input wire logic addr4Mode,
    output fpesc_frame_t frame,
    output logic opStrobe,
    output logic [7:0] opByte
);
    typedef struct packed {
        logic [1:0] csS, ckS;
        logic [7:0] d0S, d1S;
        logic ckPrev, csPrev;
        logic [2:0] bitCnt;
        logic [7:0] shift;
        logic [5:0] bytes;
        logic [7:0] opcode;
        logic [31:0] addr;
        fpesc_frame_t frame;
        logic opStrobe;
    } fpesc_rx_t;
    fpesc_rx_t s_q, s_d;
    logic [7:0] nextShift;
    logic [2:0] nextCnt;
    logic byteDone;
    logic addr4;

    always_comb begin
        s_d = s_q;
        s_d.csS = {s_q.csS[0], chipSelN};
        s_d.ckS = {s_q.ckS[0], serialClk};
        s_d.d0S = {s_q.d0S[3:0], serialDataLines};
        s_d.d1S = s_q.d0S;
        s_d.ckPrev = s_q.ckS[1];
        s_d.csPrev = s_q.csS[1];
        s_d.frame.valid = 1'b0;
        s_d.opStrobe = 1'b0;
        nextShift = s_q.shift;
        nextCnt = s_q.bitCnt;
        byteDone = 1'b0;
        // Opcode always single line; later bytes use the configured width
        unique case (s_q.bytes == 6'h00 ? 2'b00 : lineMode)
            2'b01: begin
                nextShift = {s_q.shift[5:0], s_q.d1S[1:0]};
                nextCnt = s_q.bitCnt + 3'h2;
            end
            2'b10: begin
                nextShift = {s_q.shift[3:0], s_q.d1S[3:0]};
                nextCnt = s_q.bitCnt + 3'h4;
            end
            default: begin
                nextShift = {s_q.shift[6:0], s_q.d1S[0]};
                nextCnt = s_q.bitCnt + 3'h1;
            end
        endcase
        byteDone = (nextCnt == 3'h0);
        addr4 = addr4Mode || s_q.opcode == OP_PP4 || s_q.opcode == OP_QPP4;
        if (!s_q.csS[1] && s_q.ckS[1] && !s_q.ckPrev) begin
            s_d.shift = nextShift;
            s_d.bitCnt = nextCnt;
            if (byteDone) begin
                if (s_q.bytes == 6'h00) begin
                    s_d.opcode = nextShift;
                    s_d.opStrobe = 1'b1;
                end else if (s_q.bytes <= (addr4 ? 6'h04 : 6'h03)) begin
                    s_d.addr = {s_q.addr[23:0], nextShift};
                end
                if (s_q.bytes != 6'h3f) begin
                    s_d.bytes = s_q.bytes + 6'h01;
                end
            end
        end
        if (s_q.csS[1] && !s_q.csPrev) begin
            s_d.frame.valid = 1'b1;
            s_d.frame.opcode = s_q.opcode;
            s_d.frame.addr = addr4 ? s_q.addr : {8'h00, s_q.addr[23:0]};
            s_d.frame.bytes = s_q.bytes;
            s_d.frame.aligned = (s_q.bitCnt == 3'h0);
        end
        if (s_q.csS[1]) begin
            s_d.bitCnt = 3'h0;
            s_d.bytes = 6'h00;
            s_d.addr = 32'h0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= '{csS: 2'b11, csPrev: 1'b1, default: '0};
        end else if (clkEn) begin
            s_q <= s_d;
        end
    end

    assign frame = s_q.frame;
    assign opStrobe = s_q.opStrobe;
    assign opByte = s_q.opcode;
endmodule
`default_nettype wire

//--- core/fpesc_sequencer.sv
// Program/erase/suspend sequencer top: decodes frames and runs the timers.
// Assumes protection and lock status come in as plain levels from the array.
`default_nettype none
module fpesc_sequencer
    import fpesc_pkg::*;
#(
    parameter logic [7:0] OP_SSE = 8'h20,
    parameter logic [7:0] OP_SE = 8'hd8,
    parameter logic [7:0] OP_DIE = 8'hc4,
    parameter int unsigned PROG_CYC = 5000,
    parameter int unsigned SSE_CYC = 10000,
    parameter int unsigned SE_CYC = 20000,
    parameter int unsigned DIE_CYC = 40000,
    parameter int unsigned PROG_LIMIT = 10000,
    parameter int unsigned SSE_LIMIT = 20000,
    parameter int unsigned SE_LIMIT = 40000,
    parameter int unsigned DIE_LIMIT = 80000
)(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic chipSelN,
    input wire logic serialClk,
    input wire logic [3:0] serialDataLines,
    input wire logic [1:0] lineMode,
    input wire logic addr4Default,
    input wire logic targetProtected,
    input wire logic anySectorLocked,
    input wire logic arrayStall,
    output logic writeEnable,
    output logic writeInProgress,
    output logic [7:0] flagStatus,
    output logic addr4Mode,
    output logic eraseStrobe,
    output logic [1:0] eraseKind,
    output logic [31:0] eraseAddr
);
    typedef struct packed {
        logic wel;
        logic [7:0] flags;
        logic addr4;
        logic cfgTaken;
        fpesc_op_t run;
        fpesc_op_t parkErase;
        fpesc_op_t parkProg;
        logic suspPend;
        logic [7:0] suspCnt;
        logic eraseStrobe;
        logic [1:0] eraseKind;
        logic [31:0] eraseAddr;
    } fpesc_seq_t;
    fpesc_seq_t s_q, s_d;
    fpesc_frame_t frame;
    logic opStrobe;
    logic [7:0] opByte;
    logic isErase, isProg;
    fpesc_kind_t kind;
    logic [31:0] durCyc;

    fpesc_link_rx u_rx (
        .clk_sys(clk_sys),
        .rst(rst),
        .clkEn(clkEn),
        .chipSelN(chipSelN),
        .serialClk(serialClk),
        .serialDataLines(serialDataLines),
        .lineMode(lineMode),
        .addr4Mode(s_q.addr4),
        .frame(frame),
        .opStrobe(opStrobe),
        .opByte(opByte)
    );

    function automatic logic [31:0] limitOf(input fpesc_kind_t k);
        unique case (k)
            FPESC_K_PROG: limitOf = 32'(PROG_LIMIT);
            FPESC_K_SSE: limitOf = 32'(SSE_LIMIT);
            FPESC_K_SE: limitOf = 32'(SE_LIMIT);
            FPESC_K_DIE: limitOf = 32'(DIE_LIMIT);
        endcase
    endfunction

    always_comb begin
        s_d = s_q;
        s_d.eraseStrobe = 1'b0;
        isErase = frame.opcode == OP_SSE || frame.opcode == OP_SE || frame.opcode == OP_DIE;
        isProg = frame.opcode == OP_PP || frame.opcode == OP_QPP || frame.opcode == OP_PP4
            || frame.opcode == OP_QPP4;
        kind = FPESC_K_PROG;
        durCyc = 32'(PROG_CYC);
        if (frame.opcode == OP_SSE) begin
            kind = FPESC_K_SSE;
            durCyc = 32'(SSE_CYC);
        end else if (frame.opcode == OP_SE) begin
            kind = FPESC_K_SE;
            durCyc = 32'(SE_CYC);
        end else if (frame.opcode == OP_DIE) begin
            kind = FPESC_K_DIE;
            durCyc = 32'(DIE_CYC);
        end
        // Non-volatile default caught once after reset release
        if (!s_q.cfgTaken) begin
            s_d.cfgTaken = 1'b1;
            s_d.addr4 = addr4Default;
        end
        // Running operation: suspend latency then park, or complete
        if (s_q.run.active && !arrayStall) begin
            s_d.run.remain = s_q.run.remain - 32'h1;
            s_d.run.elapsed = s_q.run.elapsed + 32'h1;
            if (s_q.run.remain <= 32'h1) begin
                s_d.run.active = 1'b0;
                s_d.wel = 1'b0;
                s_d.flags[FLAG_READY] = 1'b1;
                s_d.suspPend = 1'b0;
                if (s_q.suspPend) begin
                    s_d.flags[s_q.run.kind == FPESC_K_PROG ? FLAG_PGSUSP : FLAG_ERSUSP] = 1'b0;
                end
                if (s_q.run.kind != FPESC_K_PROG) begin
                    s_d.eraseStrobe = 1'b1;
                    s_d.eraseKind = s_q.run.kind;
                    s_d.eraseAddr = s_q.run.addr;
                end
            end else if (s_q.run.elapsed >= limitOf(s_q.run.kind)) begin
                s_d.run.active = 1'b0;
                s_d.wel = 1'b0;
                s_d.flags[FLAG_READY] = 1'b1;
                s_d.flags[s_q.run.kind == FPESC_K_PROG ? FLAG_PGERR : FLAG_ERERR] = 1'b1;
                s_d.suspPend = 1'b0;
            end else if (s_q.suspPend) begin
                s_d.suspCnt = s_q.suspCnt + 8'h01;
                if (s_q.suspCnt >= 8'(SUSP_LAT_CYC - 1)) begin
                    s_d.suspPend = 1'b0;
                    s_d.flags[FLAG_READY] = 1'b1;
                    s_d.run.active = 1'b0;
                    if (s_q.run.kind == FPESC_K_PROG) begin
                        s_d.parkProg = s_q.run;
                    end else begin
                        s_d.parkErase = s_q.run;
                    end
                end
            end
        end
        // Not on a finishing cycle, or the suspend flag would stick with nothing parked
        if (opStrobe && opByte == OP_SUSP && s_d.run.active && !s_q.suspPend) begin
            s_d.suspPend = 1'b1;
            s_d.suspCnt = 8'h00;
            s_d.flags[s_q.run.kind == FPESC_K_PROG ? FLAG_PGSUSP : FLAG_ERSUSP] = 1'b1;
        end
        if (frame.valid && frame.aligned && frame.bytes != 6'h00) begin
            if (frame.opcode == OP_WREN) begin
                s_d.wel = 1'b1;
            end else if (frame.opcode == OP_EN4) begin
                s_d.addr4 = 1'b1;
            end else if (frame.opcode == OP_EX4) begin
                s_d.addr4 = 1'b0;
            end else if (frame.opcode == OP_CLRF) begin
                s_d.flags[FLAG_ERERR] = 1'b0;
                s_d.flags[FLAG_PGERR] = 1'b0;
                s_d.flags[FLAG_PROT] = 1'b0;
            end else if (frame.opcode == OP_RESM && !s_q.run.active) begin
                if (s_q.parkProg.active) begin
                    s_d.run = s_q.parkProg;
                    s_d.parkProg.active = 1'b0;
                    s_d.flags[FLAG_PGSUSP] = 1'b0;
                    s_d.flags[FLAG_READY] = 1'b0;
                end else if (s_q.parkErase.active) begin
                    s_d.run = s_q.parkErase;
                    s_d.parkErase.active = 1'b0;
                    s_d.flags[FLAG_ERSUSP] = 1'b0;
                    s_d.flags[FLAG_READY] = 1'b0;
                end
            end else if ((isErase || isProg) && s_q.wel && !s_q.run.active) begin
                if (isProg && s_q.parkErase.active && frame.opcode != OP_SUSP
                    && frame.addr[31:SECTOR_LSB] == s_q.parkErase.addr[31:SECTOR_LSB]) begin
                    s_d.flags[FLAG_PGERR] = 1'b1;
                end else if ((isErase && s_q.parkErase.active) || (isProg && s_q.parkProg.active)) begin
                    s_d.flags[FLAG_PROT] = 1'b1;
                end else if (targetProtected || (kind == FPESC_K_DIE && anySectorLocked)) begin
                    s_d.flags[FLAG_PROT] = 1'b1;
                    s_d.flags[isProg ? FLAG_PGERR : FLAG_ERERR] = 1'b1;
                end else begin
                    s_d.run.active = 1'b1;
                    s_d.run.kind = kind;
                    s_d.run.addr = frame.addr;
                    s_d.run.remain = durCyc;
                    s_d.run.elapsed = 32'h0;
                    s_d.flags[FLAG_READY] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= '{flags: FLAG_RESET, default: '0};
        end else if (clkEn) begin
            s_q <= s_d;
        end
    end

    assign writeEnable = s_q.wel;
    assign writeInProgress = s_q.run.active;
    assign flagStatus = s_q.flags;
    assign addr4Mode = s_q.addr4;
    assign eraseStrobe = s_q.eraseStrobe;
    assign eraseKind = s_q.eraseKind;
    assign eraseAddr = s_q.eraseAddr;
endmodule
`default_nettype wire

//--- bench/fpesc_host_model.sv
// Host controller model driving the serial link of the sequencer.
// Assumes opcode on one line, later bits on 1, 2 or 4 lines; link clock period 125 ns.
`default_nettype none
module fpesc_host_model (
    output var logic chipSelN,
    output var logic serialClk,
    output var logic [3:0] serialDataLines
);
    timeunit 1ns;
    timeprecision 100ps;
    // Clock stands low between frames; released lines show inverted data
    initial begin
        chipSelN = 1'b1;
        serialClk = 1'b0;
        serialDataLines = 4'h5;
    end
    task automatic frame(input logic [7:0] op, input int nA, input logic [31:0] a, input int nX, input int w);
        logic [63:0] sh;
        int lanes;
        sh = {op, a << (8 * (4 - nA)), 24'h0};
        chipSelN = 1'b0;
        for (int i = 0; i < 8 + 8 * nA + nX; i += lanes) begin
            lanes = (i < 8) ? 1 : w;
            serialDataLines = sh[63 - i -: 4] >> (4 - lanes);
            #62.5 serialClk = 1'b1;
            #62.5 serialClk = 1'b0;
        end
        #62.5 chipSelN = 1'b1;
        serialDataLines = ~serialDataLines;
        #250;
    endtask
endmodule
`default_nettype wire

//--- bench/fpesc_sequencer_checker.sv
// Concurrent checks on the sequencer top ports.
// Assumes it is bound into fpesc_sequencer.
`default_nettype none
module fpesc_sequencer_checker
    import fpesc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic writeEnable,
    input wire logic writeInProgress,
    input wire logic [7:0] flagStatus,
    input wire logic eraseStrobe,
    input wire logic [1:0] eraseKind
);
    timeunit 1ns;
    timeprecision 100ps;
    // Suspend latency plus sync slack
    localparam int LAT_MAX = 14;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_ready_busy;
        flagStatus[FLAG_READY] == !writeInProgress;
    endproperty
    a_ready_busy: assert property (p_ready_busy) else $error("ready flag disagrees with busy");
    property p_strobe_done;
        eraseStrobe |-> ##[0:1] (!writeEnable && !writeInProgress);
    endproperty
    a_strobe_done: assert property (p_strobe_done) else $error("erase end left latch or busy");
    property p_strobe_pulse;
        eraseStrobe |=> !eraseStrobe;
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("erase strobe too long");
    property p_strobe_kind;
        eraseStrobe |-> eraseKind != 2'b00;
    endproperty
    a_strobe_kind: assert property (p_strobe_kind) else $error("erase strobe without kind");
    property p_kind_held;
        eraseStrobe |=> $stable(eraseKind) [*4];
    endproperty
    a_kind_held: assert property (p_kind_held) else $error("erase kind not held");
    property p_susp_lat;
        ($rose(flagStatus[FLAG_ERSUSP]) || $rose(flagStatus[FLAG_PGSUSP])) && writeInProgress
            |-> ##[1:LAT_MAX] !writeInProgress;
    endproperty
    a_susp_lat: assert property (p_susp_lat) else $error("suspend latency exceeded");
    property p_prot_wel;
        $rose(flagStatus[FLAG_PROT]) |-> writeEnable && !writeInProgress;
    endproperty
    a_prot_wel: assert property (p_prot_wel) else $error("refusal dropped latch");
    property p_reset_flags;
        $fell(rst) |-> flagStatus == FLAG_RESET && !writeInProgress;
    endproperty
    a_reset_flags: assert property (p_reset_flags) else $error("flags not 80h after reset");
    property p_err_ready;
        $rose(flagStatus[FLAG_ERERR]) |-> flagStatus[FLAG_READY];
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("erase error while busy");
endmodule
bind fpesc_sequencer fpesc_sequencer_checker u_fpesc_sequencer_checker (.clk_sys(clk_sys), .rst(rst),
    .writeEnable(writeEnable), .writeInProgress(writeInProgress), .flagStatus(flagStatus),
    .eraseStrobe(eraseStrobe), .eraseKind(eraseKind));
`default_nettype wire

//--- bench/fpesc_sequencer_tb.sv
// Self-checking bench for the program/erase/suspend sequencer.
// Assumes the host model drives the link; timers are shortened.
`default_nettype none
module fpesc_sequencer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {
        logic [7:0] op;
        int nA;
        logic [31:0] addr;
        int nX;
        logic [1:0] pl;
        logic [7:0] flg;
        logic [3:0] wak;
    } fpesc_row_t;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic prot = 1'b0;
    logic lock = 1'b0;
    logic clkEn = 1'b1;
    logic [1:0] lineMode = 2'b00;
    logic addr4Default = 1'b0;
    logic arrayStall = 1'b0;
    logic chipSelN, serialClk, writeEnable, writeInProgress, addr4Mode, eraseStrobe;
    logic [3:0] serialDataLines;
    logic [7:0] flagStatus;
    logic [1:0] eraseKind, lastKind;
    logic [31:0] eraseAddr, lastAddr;
    int err_count = 0;
    int checks_done = 0;
    int strobes = 0;
    int n;
    // Columns: opcode, addr bytes, addr, extra bits, {prot,lock}, flags, {wel,addr4,kind}
    fpesc_row_t rows[19] = '{
        '{8'h20, 3, 32'h12345, 0, 2'b00, 8'h80, 4'h0}, '{8'h06, 0, 0, 0, 2'b00, 8'h80, 4'h8},
        '{8'h20, 3, 32'h1000, 5, 2'b00, 8'h80, 4'h8}, '{8'h20, 3, 32'h1000, 0, 2'b10, 8'ha2, 4'h8},
        '{8'h50, 0, 0, 0, 2'b00, 8'h80, 4'h8}, '{8'hc4, 3, 0, 0, 2'b01, 8'ha2, 4'h8},
        '{8'h50, 0, 0, 0, 2'b00, 8'h80, 4'h8}, '{8'h20, 3, 32'habcdef, 0, 2'b00, 8'h80, 4'h1},
        '{8'h06, 0, 0, 0, 2'b00, 8'h80, 4'h8}, '{8'hd8, 3, 32'h123456, 0, 2'b00, 8'h80, 4'h2},
        '{8'h06, 0, 0, 0, 2'b00, 8'h80, 4'h8}, '{8'hc4, 3, 0, 0, 2'b00, 8'h80, 4'h3},
        '{8'hb7, 0, 0, 0, 2'b00, 8'h80, 4'h4}, '{8'h06, 0, 0, 0, 2'b00, 8'h80, 4'hc},
        '{8'h20, 4, 32'hfedcba98, 0, 2'b00, 8'h80, 4'h5}, '{8'he9, 0, 0, 0, 2'b00, 8'h80, 4'h0},
        '{8'h7a, 0, 0, 0, 2'b00, 8'h80, 4'h0}, '{8'h06, 0, 0, 0, 2'b00, 8'h80, 4'h8},
        '{8'h12, 4, 32'h80000000, 8, 2'b00, 8'h80, 4'h0}};
    always #2 clk_sys = ~clk_sys;
    fpesc_sequencer #(.PROG_CYC(2000), .SSE_CYC(60), .SE_CYC(2000), .DIE_CYC(100)) u_fpesc_sequencer (
        .clk_sys(clk_sys), .rst(rst),
        .clkEn(clkEn), .chipSelN(chipSelN), .serialClk(serialClk), .serialDataLines(serialDataLines),
        .lineMode(lineMode), .addr4Default(addr4Default), .targetProtected(prot), .anySectorLocked(lock),
        .arrayStall(arrayStall), .writeEnable(writeEnable), .writeInProgress(writeInProgress),
        .flagStatus(flagStatus), .addr4Mode(addr4Mode), .eraseStrobe(eraseStrobe),
        .eraseKind(eraseKind), .eraseAddr(eraseAddr));
    fpesc_host_model u_fpesc_host_model (.chipSelN(chipSelN), .serialClk(serialClk),
        .serialDataLines(serialDataLines));
    always @(posedge clk_sys) if (eraseStrobe === 1'b1) begin
        strobes++;
        lastKind <= eraseKind;
        lastAddr <= eraseAddr;
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("errors=%0d checks=%0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Optionally waits for the array to go idle, bounded
    task automatic send(input logic [7:0] op, input int nA = 0, input logic [31:0] a = 0,
        input int nX = 0, input bit wt = 1, input int w = 1);
        u_fpesc_host_model.frame(op, nA, a, nX, w);
        repeat (20) @(posedge clk_sys);
        for (int i = 0; wt && i < 5000 && writeInProgress !== 1'b0; i++) @(posedge clk_sys);
        // Look after the edge so the strobe counter and captured kind have settled
        #1;
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        #1 rst = 1'b0;
        repeat (5) @(posedge clk_sys);
        foreach (rows[i]) begin
            @(posedge clk_sys);
            #1 {prot, lock} = rows[i].pl;
            n = strobes;
            send(rows[i].op, rows[i].nA, rows[i].addr, rows[i].nX);
            chk(flagStatus, rows[i].flg);
            chk({writeEnable, addr4Mode}, rows[i].wak[3:2]);
            if (rows[i].wak[1:0] != 2'b00) begin
                chk(strobes - n, 1);
                chk({lastKind, lastAddr}, {rows[i].wak[1:0], rows[i].addr});
            end
        end
        // Address bytes on four, then two lines
        lineMode = 2'b10;
        send(8'h06);
        n = strobes;
        send(8'h20, 3, 32'h2468ac, 0, 1, 4);
        chk({strobes - n, lastAddr}, {32'h1, 32'h2468ac});
        lineMode = 2'b01;
        send(8'h06);
        send(8'h20, 3, 32'h13579b, 0, 1, 2);
        chk({strobes - n, lastAddr}, {32'h2, 32'h13579b});
        lineMode = 2'b00;
        // Frozen enable, then stalled array, both stretch a running erase
        send(8'h06);
        n = strobes;
        send(8'hd8, 3, 32'h60000, 0, 0);
        clkEn = 1'b0;
        repeat (200) @(posedge clk_sys);
        #1 chk({writeInProgress, strobes - n}, {1'b1, 32'h0});
        {clkEn, arrayStall} = 2'b11;
        repeat (200) @(posedge clk_sys);
        #1 chk({writeInProgress, strobes - n}, {1'b1, 32'h0});
        arrayStall = 1'b0;
        repeat (2100) @(posedge clk_sys);
        #1 chk({writeInProgress, strobes - n, writeEnable}, {1'b0, 32'h1, 1'b0});
        send(8'h06);
        send(8'hd8, 3, 32'h50000, 0, 0);
        chk({writeInProgress, flagStatus[7]}, 2'b10);
        send(8'h75);
        chk({flagStatus, writeInProgress}, {8'hc0, 1'b0});
        send(8'h06);
        send(8'h02, 3, 32'h50100, 8);
        chk({flagStatus, writeEnable}, {8'hd0, 1'b1});
        send(8'h50);
        send(8'h02, 3, 32'h70000, 8, 0);
        send(8'h75);
        chk(flagStatus, 8'hc4);
        n = strobes;
        send(8'h7a);
        chk({flagStatus, writeEnable, strobes - n}, {8'hc0, 1'b0, 32'h0});
        send(8'h7a);
        chk({flagStatus, lastKind, strobes - n}, {8'h80, 2'h2, 32'h1});
        send(8'h06);
        send(8'hd8, 3, 32'h50000, 0, 0);
        send(8'h75);
        @(posedge clk_sys);
        #1 rst = 1'b1;
        addr4Default = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 rst = 1'b0;
        chk({flagStatus, writeInProgress, writeEnable}, {8'h80, 2'b00});
        repeat (5) @(posedge clk_sys);
        #1 chk(addr4Mode, 1);
        send(8'h7a);
        chk({flagStatus, writeInProgress}, {8'h80, 1'b0});
        complete_run();
    end
    initial begin
        #300000;
        err_count++;
        complete_run();
    end
endmodule
`default_nettype wire
